// File: hw/spm_consts.vh
// Constants for the serial peripheral master: reset values, transfer shape and clock divider.
`ifndef SPM_CONSTS_VH
`define SPM_CONSTS_VH
// ==========================================
// Reset values
`define SPM_RST_SEL_UPPER 1'b0
`define SPM_RST_SEL_LOWER 1'b1
// ==========================================
// Transfer shape
`define SPM_BITS_PER_BYTE 8
`define SPM_BIT_CNT_W 4
// ==========================================
// Serial clock: half period in system clocks
`define SPM_SCK_HALF_NS 400
`define SPM_CLK_PERIOD_NS 100
`define SPM_SCK_HALF_CYC ((`SPM_SCK_HALF_NS + `SPM_CLK_PERIOD_NS - 1) / `SPM_CLK_PERIOD_NS)
`endif

// File: hw/spm_serial_peripheral_master.v
// Master-mode serial peripheral port with transmit and receive buffers and slave-select modes.
//
// Operation
// - Port acts as master only while master enable flag is set.
// - Data register write in master mode loads the transmit buffer.
// - Empty shifter and full transmit buffer start a transfer.
// - During transfer drive SCK and shift the byte out on MOSI.
// - Transfer done flag sets at end of each transfer.
// - Done flag with interrupts enabled raises an interrupt request.
// - Received bits shift in most significant bit first.
// - Finished byte moves to receive buffer, read via data register.
// - Upper select bit 0, lower 1 means multi-master, the reset default.
// - Multi-master: select low clears enables and sets mode fault flag.
// - Mode fault flag with interrupt enabled raises an interrupt request.
// - Both select bits 0 means 3-wire mode, select line unused.
// - Upper select bit 1 means 4-wire mode, select line driven out.
// - In 4-wire mode select output equals lower select bit.
`timescale 1ns/1ns
`include "spm_consts.vh"

module spm_serial_peripheral_master
#(
    parameter BITS = `SPM_BITS_PER_BYTE,
    parameter HALF = `SPM_SCK_HALF_CYC
)
(
    input wire clk_i,
    input wire reset_i,
    input wire port_enable_set_i,
    input wire port_enable_clr_i,
    input wire master_enable_set_i,
    input wire master_enable_clr_i,
    input wire sel_mode_wr_i,
    input wire select_mode_upper_bit_i,
    input wire select_mode_lower_bit_i,
    input wire irq_enable_i,
    input wire data_wr_i,
    input wire [BITS-1:0] data_wdata_i,
    input wire done_clr_i,
    input wire fault_clr_i,
    input wire miso_i,
    input wire slave_select_line_i,
    output reg [BITS-1:0] rx_data_o,
    output reg transfer_done_flag_o,
    output reg mode_fault_flag_o,
    output reg master_enable_flag_o,
    output reg port_enable_bit_o,
    output reg select_mode_upper_bit_o,
    output reg select_mode_lower_bit_o,
    output wire busy_o,
    output wire tx_full_o,
    output wire irq_o,
    output reg sck_o,
    output reg mosi_o,
    output reg slave_select_line_o,
    output wire slave_select_line_oe_n_o
);

    localparam ST_IDLE = 1'b0;
    localparam ST_SHIFT = 1'b1;
    localparam integer HALF_M1_INT = HALF - 1;
    localparam integer LAST_BIT_INT = BITS - 1;
    // Counter compare values cut to the counter widths on purpose.
    localparam [7:0] HALF_M1 = HALF_M1_INT[7:0];
    localparam [`SPM_BIT_CNT_W-1:0] LAST_BIT = LAST_BIT_INT[`SPM_BIT_CNT_W-1:0];

    reg state;
    reg [BITS-1:0] tx_buf;
    reg tx_valid;
    reg [BITS-1:0] shifter;
    reg [`SPM_BIT_CNT_W-1:0] bit_cnt;
    reg [7:0] half_cnt;
    reg miso_s1, miso_s2;
    reg ss_s1, ss_s2;

    // ==========================================
    // Input synchronisers
    // Two flops per pin before any logic reads it.
    always @(posedge clk_i)
    begin
        if (reset_i)
        begin
            miso_s1 <= 1'b0;
            miso_s2 <= 1'b0;
            ss_s1 <= 1'b1;
            ss_s2 <= 1'b1;
        end
        else
        begin
            miso_s1 <= miso_i;
            miso_s2 <= miso_s1;
            ss_s1 <= slave_select_line_i;
            ss_s2 <= ss_s1;
        end
    end

    // Mode decode from the select mode bits.
    // multi-master decode
    wire multi_master = ~select_mode_upper_bit_o & select_mode_lower_bit_o;
    wire fault = multi_master & ~ss_s2 & master_enable_flag_o;
    wire active = master_enable_flag_o & port_enable_bit_o;

    // ==========================================
    // Control and status flags
    // Set wins over clear on both hardware flags.
    always @(posedge clk_i)
    begin
        if (reset_i)
        begin
            master_enable_flag_o <= 1'b0;
            port_enable_bit_o <= 1'b0;
            select_mode_upper_bit_o <= `SPM_RST_SEL_UPPER;
            select_mode_lower_bit_o <= `SPM_RST_SEL_LOWER;
            mode_fault_flag_o <= 1'b0;
        end
        else
        begin
            if (sel_mode_wr_i)
            begin
                select_mode_upper_bit_o <= select_mode_upper_bit_i;
                select_mode_lower_bit_o <= select_mode_lower_bit_i;
            end
            if (master_enable_set_i)
                master_enable_flag_o <= 1'b1;
            else if (master_enable_clr_i)
                master_enable_flag_o <= 1'b0;
            if (port_enable_set_i)
                port_enable_bit_o <= 1'b1;
            else if (port_enable_clr_i)
                port_enable_bit_o <= 1'b0;
            if (fault)
            begin
                master_enable_flag_o <= 1'b0;
                port_enable_bit_o <= 1'b0;
                mode_fault_flag_o <= 1'b1;
            end
            else if (fault_clr_i)
                mode_fault_flag_o <= 1'b0;
        end
    end

    // ==========================================
    // Transfer engine
    // Holds transmit buffer, shifter, SCK timing and receive buffer.
    always @(posedge clk_i)
    begin
        if (reset_i)
        begin
            state <= ST_IDLE;
            tx_buf <= {BITS{1'b0}};
            tx_valid <= 1'b0;
            shifter <= {BITS{1'b0}};
            bit_cnt <= {`SPM_BIT_CNT_W{1'b0}};
            half_cnt <= 8'h00;
            sck_o <= 1'b0;
            mosi_o <= 1'b0;
            rx_data_o <= {BITS{1'b0}};
            transfer_done_flag_o <= 1'b0;
        end
        else
        begin
            if (data_wr_i & master_enable_flag_o)
            begin
                tx_buf <= data_wdata_i;
                tx_valid <= 1'b1;
            end
            if (done_clr_i)
                transfer_done_flag_o <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    sck_o <= 1'b0;
                    if (tx_valid & active & ~fault)
                    begin
                        shifter <= tx_buf;
                        mosi_o <= tx_buf[BITS-1];
                        tx_valid <= data_wr_i & master_enable_flag_o;
                        bit_cnt <= {`SPM_BIT_CNT_W{1'b0}};
                        half_cnt <= 8'h00;
                        state <= ST_SHIFT;
                    end
                end
                ST_SHIFT:
                begin
                    if (~active)
                    begin
                        // Fault or disable aborts the byte with SCK parked low.
                        sck_o <= 1'b0;
                        state <= ST_IDLE;
                    end
                    else if (half_cnt == HALF_M1)
                    begin
                        half_cnt <= 8'h00;
                        sck_o <= ~sck_o;
                        if (~sck_o)
                        begin
                            // sample MISO into LSB, MSB arrives first
                            shifter <= {shifter[BITS-2:0], miso_s2};
                        end
                        else
                        begin
                            if (bit_cnt == LAST_BIT)
                            begin
                                rx_data_o <= shifter;
                                transfer_done_flag_o <= 1'b1;
                                state <= ST_IDLE;
                            end
                            else
                            begin
                                bit_cnt <= bit_cnt + 1'b1;
                                mosi_o <= shifter[BITS-1];
                            end
                        end
                    end
                    else
                        half_cnt <= half_cnt + 8'h01;
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // ==========================================
    // Select line output and status
    // 4-wire drives select, 3-wire and multi-master leave it released
    always @(posedge clk_i)
    begin
        if (reset_i)
            slave_select_line_o <= 1'b1;
        else if (sel_mode_wr_i)
            // select follows lower bit, loaded with it so both change on one edge
            slave_select_line_o <= select_mode_lower_bit_i;
    end
    assign slave_select_line_oe_n_o = ~select_mode_upper_bit_o;

    assign irq_o = irq_enable_i & (transfer_done_flag_o | mode_fault_flag_o);
    assign busy_o = (state == ST_SHIFT);
    assign tx_full_o = tx_valid;

endmodule // spm_serial_peripheral_master

// File: verification/spm_slave_model.sv
// Behavioural slave that swaps one byte with the master per transfer.
`timescale 1ns/1ns
module spm_slave_model
(
    input wire sck_i,
    input wire mosi_i,
    output wire miso_o
);
    reg [7:0] shr;
    reg cap;
    always @(posedge sck_i)
        cap <= mosi_i;
    // shift on fall, MSB leaves first
    always @(negedge sck_i)
        shr <= {shr[6:0], cap};
    assign miso_o = shr[7];
endmodule // spm_slave_model

// File: verification/spm_monitor.sv
// Checker of the serial peripheral master port behaviour.
`timescale 1ns/1ns
module spm_monitor
(
    input wire clk_i,
    input wire reset_i,
    input wire data_wr_i,
    input wire slave_select_line_i,
    input wire irq_enable_i,
    input wire transfer_done_flag_o,
    input wire mode_fault_flag_o,
    input wire master_enable_flag_o,
    input wire port_enable_bit_o,
    input wire select_mode_upper_bit_o,
    input wire select_mode_lower_bit_o,
    input wire busy_o,
    input wire tx_full_o,
    input wire irq_o,
    input wire sck_o,
    input wire slave_select_line_o,
    input wire slave_select_line_oe_n_o
);
    reg [3:0] cnt;
    reg sck_q;
    reg done_q;
    // Counts serial clock rises within one byte.
    always @(posedge clk_i)
    begin
        sck_q <= sck_o;
        done_q <= transfer_done_flag_o;
        if (reset_i || !busy_o || (transfer_done_flag_o && !done_q))
            cnt <= 4'h0;
        else if (sck_o && !sck_q)
            cnt <= cnt + 4'h1;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    sequence sq_take;
        data_wr_i && master_enable_flag_o && port_enable_bit_o && !busy_o && !tx_full_o;
    endsequence
    sequence sq_ss_low;
        (!slave_select_line_i) [*3] ##0 (!select_mode_upper_bit_o && select_mode_lower_bit_o && master_enable_flag_o);
    endsequence
    a_reset_state: assert property ($fell(reset_i) |-> !master_enable_flag_o && !port_enable_bit_o &&
        !transfer_done_flag_o && !mode_fault_flag_o && !select_mode_upper_bit_o && select_mode_lower_bit_o)
        else $error("state after reset wrong");
    a_write_start: assert property (sq_take |-> ##2 busy_o)
        else $error("write did not start a transfer");
    a_refuse_write: assert property (!master_enable_flag_o && !busy_o && !tx_full_o |=> !busy_o && !tx_full_o)
        else $error("transfer without master enable");
    a_eight_clocks: assert property ($rose(transfer_done_flag_o) |-> cnt == 4'h8)
        else $error("byte did not use eight clocks");
    a_sck_idle: assert property (master_enable_flag_o && !busy_o |-> !sck_o)
        else $error("serial clock moved while idle");
    a_fault_trip: assert property (sq_ss_low |-> ##[1:2] (mode_fault_flag_o && !master_enable_flag_o))
        else $error("select low gave no mode fault");
    a_ss_drive: assert property (select_mode_upper_bit_o |-> !slave_select_line_oe_n_o &&
        slave_select_line_o == select_mode_lower_bit_o)
        else $error("select output wrong in four wire mode");
    a_ss_unused: assert property (!select_mode_upper_bit_o |-> slave_select_line_oe_n_o)
        else $error("select driven outside four wire mode");
    a_irq_gate: assert property (irq_o == (irq_enable_i && (transfer_done_flag_o || mode_fault_flag_o)))
        else $error("interrupt request wrong");
endmodule // spm_monitor
bind spm_serial_peripheral_master spm_monitor i_mon (.*);

// File: verification/spm_serial_peripheral_master_tb.sv
// Self-checking bench of the serial peripheral master.
`timescale 1ns/1ns
module spm_serial_peripheral_master_tb;
    reg clk_i, reset_i, irq_enable_i, slave_select_line_i, select_mode_upper_bit_i, select_mode_lower_bit_i;
    reg [7:0] ctl, data_wdata_i;
    wire port_enable_set_i = ctl[7], port_enable_clr_i = ctl[6], master_enable_set_i = ctl[5];
    wire master_enable_clr_i = ctl[4], sel_mode_wr_i = ctl[3], data_wr_i = ctl[2];
    wire done_clr_i = ctl[1], fault_clr_i = ctl[0];
    wire [7:0] rx_data_o;
    wire transfer_done_flag_o, mode_fault_flag_o, master_enable_flag_o, port_enable_bit_o, select_mode_upper_bit_o;
    wire select_mode_lower_bit_o, busy_o, tx_full_o, irq_o, sck_o, mosi_o, slave_select_line_o;
    wire slave_select_line_oe_n_o, miso_i;
    integer bad_count, samples_checked, cyc, k, j;
    spm_serial_peripheral_master i_dut (.*);
    spm_slave_model i_slave (.sck_i(sck_o), .mosi_i(mosi_o), .miso_o(miso_i));
    // ==========================================
    // Clock and hang guard
    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 2000)
        begin
            bad_count = bad_count + 1;
            test_done;
        end
    end
    // ==========================================
    // Tasks
    task chk(input string nm, input [7:0] seen, input [7:0] exp);
    begin
        samples_checked = samples_checked + 1;
        if (seen !== exp)
        begin
            bad_count = bad_count + 1;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    end
    endtask
    task pulse(input [7:0] p, input [7:0] d);
    begin
        @(posedge clk_i) {ctl, data_wdata_i} <= {p, d};
        @(posedge clk_i) ctl <= 8'h00;
        #1;
    end
    endtask
    task xfer(input [7:0] tx, input [7:0] sl);
    begin
        i_slave.shr = sl;
        pulse(8'h04, tx);
        @(posedge clk_i);
        #1;
        chk("busy", busy_o, 8'h01);
        for (k = 0; k < 300 && busy_o !== 1'b0; k = k + 1)
            @(posedge clk_i);
        #1;
        chk("rx", rx_data_o, sl);
        chk("slave", i_slave.shr, tx);
        chk("done", transfer_done_flag_o, 8'h01);
        chk("irq", irq_o, 8'h01);
        pulse(8'h02, 8'h00);
    end
    endtask
    task test_done;
    begin
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    end
    endtask
    // ==========================================
    // Main sequence
    initial
    begin
        {bad_count, samples_checked, cyc, ctl, data_wdata_i} = 0;
        {irq_enable_i, slave_select_line_i, select_mode_upper_bit_i, select_mode_lower_bit_i} = 4'hD;
        reset_i = 1'b1;
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        pulse(8'h04, 8'h11);
        chk("idle", {busy_o, select_mode_lower_bit_o}, 8'h01);
        pulse(8'hA0, 8'h00);
        for (j = 0; j < 4; j = j + 1)
        begin
            @(posedge clk_i) {select_mode_upper_bit_i, select_mode_lower_bit_i} <= j[1:0] ^ 2'h1;
            pulse(8'h08, 8'h00);
            chk("oe_n", slave_select_line_oe_n_o, j < 2);
            chk("ss", slave_select_line_o, j[0] ^ 1'b1);
            xfer(8'hA5 ^ j[7:0], 8'h3C + j[7:0]);
        end
        @(posedge clk_i) {select_mode_upper_bit_i, select_mode_lower_bit_i, slave_select_line_i} <= 3'h2;
        pulse(8'h08, 8'h00);
        repeat (4) @(posedge clk_i);
        #1;
        chk("fault", {mode_fault_flag_o, master_enable_flag_o, port_enable_bit_o, irq_o}, 8'h09);
        @(posedge clk_i) slave_select_line_i <= 1'b1;
        pulse(8'h04, 8'h77);
        chk("refused", {busy_o, tx_full_o}, 8'h00);
        pulse(8'h01, 8'h00);
        pulse(8'hA0, 8'h00);
        i_slave.shr = 8'h96;
        pulse(8'h04, 8'h5A);
        pulse(8'h04, 8'hC3);
        chk("full", tx_full_o, 8'h01);
        repeat (140) @(posedge clk_i);
        #1;
        chk("rx2", rx_data_o, 8'h5A);
        chk("slave2", i_slave.shr, 8'hC3);
        @(posedge clk_i) irq_enable_i <= 1'b0;
        #1;
        chk("irq_off", irq_o, 8'h00);
        pulse(8'h50, 8'h00);
        chk("disabled", {master_enable_flag_o, port_enable_bit_o}, 8'h00);
        test_done;
    end
endmodule // spm_serial_peripheral_master_tb
